// *** pkg/vbf_defs.svh ***
// register offsets, fields, reset values and timing counts for the bag fill sequencer
// assumes a 20 MHz aclk; included by the package and the assertion checker
`ifndef VBF_DEFS_SVH
`define VBF_DEFS_SVH

`define VBF_CLK_HZ 20000000
`define VBF_PULSE_MS 200
`define VBF_PULSE_CYC ((`VBF_CLK_HZ / 1000) * `VBF_PULSE_MS)

`define VBF_OFF_CTRL 8'h00
`define VBF_OFF_STATUS 8'h04
`define VBF_OFF_IRQ_STAT 8'h08
`define VBF_OFF_IRQ_MASK 8'h0C
`define VBF_OFF_WEIGHT 8'h10
`define VBF_OFF_TARGET 8'h14
`define VBF_OFF_TOL_LO 8'h18
`define VBF_OFF_TOL_HI 8'h1C
`define VBF_OFF_CUT_MED 8'h20
`define VBF_OFF_CUT_FINE 8'h24
`define VBF_OFF_PREACT 8'h28
`define VBF_OFF_REL_DLY 8'h2C
`define VBF_OFF_PUFF_TIME 8'h30
`define VBF_OFF_PURGE_TIME 8'h34
`define VBF_OFF_REMAP 8'h38
`define VBF_OFF_FILLED 8'h3C

`define VBF_CTRL_ENABLE 0
`define VBF_CTRL_THREE_SPEED 1
`define VBF_CTRL_AUTO_ADJ 2
`define VBF_CTRL_PUFF_SRC_LO 4
`define VBF_CTRL_PUFF_SRC_HI 5
`define VBF_CTRL_RESET_VAL 32'h0000_0007

`define VBF_IRQ_BITS 4
`define VBF_IRQ_CLAMPED 0
`define VBF_IRQ_FULL 1
`define VBF_IRQ_ERROR 2
`define VBF_IRQ_DONE 3

`define VBF_PUFF_SRC_CLAMP_OUT 2'h0
`define VBF_PUFF_SRC_CLAMP_IN 2'h1
`define VBF_PUFF_SRC_GATE_OUT 2'h2
`define VBF_PUFF_SRC_FEEDING 2'h3

`define VBF_NPORT 4
`define VBF_RESP_OKAY 2'h0
`define VBF_RESP_SLVERR 2'h2

`endif

// *** pkg/vbf_pkg.sv ***
// types for the valve bag fill sequencer
// assumes vbf_defs.svh for all numeric constants except the state encodings, which are set here
package vbf_pkg;
  `include "vbf_defs.svh"

  typedef enum logic [3:0] {
    VBF_IDLE    = 4'h0,
    VBF_CLAMP   = 4'h1,
    VBF_PUFF    = 4'h3,
    VBF_GATE    = 4'h2,
    VBF_COARSE  = 4'h6,
    VBF_MEDIUM  = 4'h7,
    VBF_FINE    = 4'h5,
    VBF_CHECK   = 4'h4,
    VBF_RELEASE = 4'hC,
    VBF_DONE    = 4'hD
  } vbf_state_e;

  typedef logic [31:0] vbf_word_t;
endpackage

// *** hw/vbf_pulse_timer.sv ***
// one-shot down counter: load starts it, busy stands for the loaded count of cycles
// assumes a synchronous active-low reset and a single clock
`timescale 1ns/100ps
module vbf_pulse_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic load,
  input wire logic [31:0] count,
  // status
  output logic busy
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
  } vbf_tmr_s;

  vbf_tmr_s st_ff;
  vbf_tmr_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (load && count != 32'h0000_0000) begin
      nxt_st.cnt = count - 32'h0000_0001;
      nxt_st.busy = 1'b1;
    end else if (st_ff.cnt != 32'h0000_0000) begin
      nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
    end else begin
      nxt_st.busy = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
endmodule

// *** hw/vbf_fill_seq.sv ***
// valve bag fill sequencer: clamp, puff, gate, staged feed, check, release
// assumes synchronous machine inputs, net weight on a port, axi4-lite register access
`timescale 1ns/100ps
module vbf_fill_seq
  import vbf_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // machine inputs, raw ports before reserve substitution
  input wire logic [3:0] in_port,
  input wire logic [15:0] net_weight,
  // machine outputs
  output logic [3:0] out_port,
  output logic medium_feed,
  output logic fine_feed,
  output logic puff_air,
  output logic exhaust_air,
  output logic vibrate,
  output logic purge_air,
  output logic full_pulse,
  output logic complete_pulse,
  output logic error_out,
  output logic valve_bag_mode,
  output logic irq
);
  typedef struct packed {
    vbf_state_e state;
    logic [31:0] ctrl;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [15:0] target;
    logic [15:0] tol_lo;
    logic [15:0] tol_hi;
    logic [15:0] cut_med;
    logic [15:0] cut_fine;
    logic [15:0] preact;
    logic [31:0] rel_dly;
    logic [31:0] puff_time;
    logic [31:0] purge_time;
    logic [7:0] remap;
    logic [15:0] filled;
    logic [31:0] dly_cnt;
    logic [3:0] out_port;
    logic medium_feed;
    logic fine_feed;
    logic puff_air;
    logic exhaust_air;
    logic vibrate;
    logic purge_air;
    logic error_out;
    logic puff_src_q;
    logic fine_q;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } vbf_top_s;

  vbf_top_s st_ff;
  vbf_top_s nxt_st;

  logic full_load;
  logic done_load;
  logic puff_load;
  logic purge_load;
  logic full_busy;
  logic done_busy;
  logic puff_busy;
  logic purge_busy;
  logic [3:0] in_map;
  logic start_in;
  logic clamp_req;
  logic gate_open_in;
  logic clamp_closed_in;

  // reserve substitution: remap[2i+1:2i] picks which raw port serves function i
  always_comb begin
    for (int i = 0; i < `VBF_NPORT; i++) begin
      in_map[i] = in_port[st_ff.remap[2*i +: 2]];
    end
  end

  assign start_in = in_map[0];
  assign clamp_req = in_map[1];
  assign gate_open_in = in_map[2];
  assign clamp_closed_in = in_map[3];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0] rd;
    logic rd_ok;
    logic [3:0] ev;
    logic [3:0] func_out;
    logic [15:0] adj;
    logic puff_src;
    logic wr_fire;
    logic [31:0] wv;
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    ev = 4'h0;
    func_out = 4'h0;
    adj = 16'h0000;
    puff_src = 1'b0;
    wr_fire = 1'b0;
    wv = 32'h0000_0000;
    nxt_st = st_ff;
    full_load = 1'b0;
    done_load = 1'b0;
    puff_load = 1'b0;
    purge_load = 1'b0;

    // sequencer
    case (st_ff.state)
      VBF_IDLE: begin
        if (st_ff.ctrl[`VBF_CTRL_ENABLE] && start_in && clamp_req) begin
          nxt_st.state = VBF_CLAMP;
          nxt_st.error_out = 1'b0;
        end
      end
      VBF_CLAMP: begin
        if (clamp_closed_in) begin
          ev[`VBF_IRQ_CLAMPED] = 1'b1;
          nxt_st.state = VBF_PUFF;
        end
      end
      VBF_PUFF: begin
        // with either clamp puff source, feeding waits for the puff pulse to finish
        if (!puff_busy && !st_ff.puff_air) begin
          nxt_st.state = VBF_GATE;
        end
      end
      VBF_GATE: begin
        if (gate_open_in) begin
          nxt_st.state = VBF_COARSE;
        end
      end
      VBF_COARSE: begin
        if (net_weight >= st_ff.cut_med) begin
          nxt_st.state = st_ff.ctrl[`VBF_CTRL_THREE_SPEED] ? VBF_MEDIUM : VBF_FINE;
        end
      end
      VBF_MEDIUM: begin
        if (net_weight >= st_ff.cut_fine) begin
          nxt_st.state = VBF_FINE;
        end
      end
      VBF_FINE: begin
        if (net_weight >= st_ff.target - st_ff.preact) begin
          nxt_st.state = VBF_CHECK;
        end
      end
      VBF_CHECK: begin
        nxt_st.filled = net_weight;
        // out of tolerance raises error but the bag is still released
        if (net_weight < st_ff.target - st_ff.tol_lo ||
            net_weight > st_ff.target + st_ff.tol_hi) begin
          nxt_st.error_out = 1'b1;
          ev[`VBF_IRQ_ERROR] = 1'b1;
        end else begin
          full_load = 1'b1;
          ev[`VBF_IRQ_FULL] = 1'b1;
        end
        // preact nudged by one count toward the overshoot; cheap and stable
        if (st_ff.ctrl[`VBF_CTRL_AUTO_ADJ]) begin
          adj = st_ff.preact;
          if (net_weight > st_ff.target && adj != 16'hFFFF) begin
            adj = adj + 16'h0001;
          end else if (net_weight < st_ff.target && adj != 16'h0000) begin
            adj = adj - 16'h0001;
          end
          nxt_st.preact = adj;
        end
        nxt_st.dly_cnt = st_ff.rel_dly;
        nxt_st.state = VBF_RELEASE;
      end
      VBF_RELEASE: begin
        if (st_ff.dly_cnt == 32'h0000_0000) begin
          nxt_st.state = VBF_DONE;
          done_load = 1'b1;
          ev[`VBF_IRQ_DONE] = 1'b1;
        end else begin
          nxt_st.dly_cnt = st_ff.dly_cnt - 32'h0000_0001;
        end
      end
      VBF_DONE: begin
        if (!clamp_req) begin
          nxt_st.state = VBF_IDLE;
        end
      end
      default: nxt_st.state = VBF_IDLE;
    endcase

    // actuator outputs
    func_out[0] = nxt_st.state == VBF_IDLE;
    func_out[1] = nxt_st.state inside {VBF_CLAMP, VBF_PUFF, VBF_GATE, VBF_COARSE,
                                       VBF_MEDIUM, VBF_FINE, VBF_CHECK, VBF_RELEASE};
    func_out[2] = nxt_st.state inside {VBF_GATE, VBF_COARSE, VBF_MEDIUM, VBF_FINE};
    func_out[3] = nxt_st.state == VBF_COARSE;
    for (int i = 0; i < `VBF_NPORT; i++) begin
      nxt_st.out_port[i] = func_out[st_ff.remap[2*i +: 2]];
    end
    nxt_st.medium_feed = nxt_st.state == VBF_MEDIUM;
    nxt_st.fine_feed = nxt_st.state == VBF_FINE ||
                       (nxt_st.state == VBF_COARSE && !st_ff.ctrl[`VBF_CTRL_THREE_SPEED]);
    nxt_st.exhaust_air = nxt_st.state inside {VBF_COARSE, VBF_MEDIUM, VBF_FINE,
                                              VBF_CHECK, VBF_RELEASE};
    nxt_st.vibrate = nxt_st.state inside {VBF_COARSE, VBF_MEDIUM, VBF_FINE};

    // puff timer fires on rising edge of the selected source
    case (st_ff.ctrl[`VBF_CTRL_PUFF_SRC_HI:`VBF_CTRL_PUFF_SRC_LO])
      `VBF_PUFF_SRC_CLAMP_OUT: puff_src = st_ff.out_port[1];
      `VBF_PUFF_SRC_CLAMP_IN: puff_src = clamp_closed_in;
      `VBF_PUFF_SRC_GATE_OUT: puff_src = st_ff.out_port[2];
      default: puff_src = st_ff.vibrate;
    endcase
    nxt_st.puff_src_q = puff_src;
    puff_load = puff_src && !st_ff.puff_src_q;
    nxt_st.puff_air = puff_busy;
    nxt_st.fine_q = st_ff.fine_feed;
    purge_load = st_ff.fine_q && !st_ff.fine_feed;
    nxt_st.purge_air = purge_busy;

    // axi4-lite write channel
    nxt_st.awready = !st_ff.aw_got && !st_ff.bvalid;
    nxt_st.wready = !st_ff.w_got && !st_ff.bvalid;
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
      nxt_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
      nxt_st.wready = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      wr_fire = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `VBF_RESP_OKAY;
      if (st_ff.aw_addr == `VBF_OFF_CTRL) begin
        nxt_st.ctrl = merge(st_ff.ctrl, st_ff.w_data, st_ff.w_strb);
      end else if (st_ff.aw_addr == `VBF_OFF_IRQ_MASK) begin
        wv = merge({28'h0, st_ff.irq_mask}, st_ff.w_data, st_ff.w_strb);
        nxt_st.irq_mask = wv[3:0];
      end else if (st_ff.aw_addr == `VBF_OFF_TARGET) begin
        wv = merge({16'h0, st_ff.target}, st_ff.w_data, st_ff.w_strb);
        nxt_st.target = wv[15:0];
      end else if (st_ff.aw_addr == `VBF_OFF_TOL_LO) begin
        wv = merge({16'h0, st_ff.tol_lo}, st_ff.w_data, st_ff.w_strb);
        nxt_st.tol_lo = wv[15:0];
      end else if (st_ff.aw_addr == `VBF_OFF_TOL_HI) begin
        wv = merge({16'h0, st_ff.tol_hi}, st_ff.w_data, st_ff.w_strb);
        nxt_st.tol_hi = wv[15:0];
      end else if (st_ff.aw_addr == `VBF_OFF_CUT_MED) begin
        wv = merge({16'h0, st_ff.cut_med}, st_ff.w_data, st_ff.w_strb);
        nxt_st.cut_med = wv[15:0];
      end else if (st_ff.aw_addr == `VBF_OFF_CUT_FINE) begin
        wv = merge({16'h0, st_ff.cut_fine}, st_ff.w_data, st_ff.w_strb);
        nxt_st.cut_fine = wv[15:0];
      end else if (st_ff.aw_addr == `VBF_OFF_PREACT) begin
        wv = merge({16'h0, nxt_st.preact}, st_ff.w_data, st_ff.w_strb);
        nxt_st.preact = wv[15:0];
      end else if (st_ff.aw_addr == `VBF_OFF_REL_DLY) begin
        nxt_st.rel_dly = merge(st_ff.rel_dly, st_ff.w_data, st_ff.w_strb);
      end else if (st_ff.aw_addr == `VBF_OFF_PUFF_TIME) begin
        nxt_st.puff_time = merge(st_ff.puff_time, st_ff.w_data, st_ff.w_strb);
      end else if (st_ff.aw_addr == `VBF_OFF_PURGE_TIME) begin
        nxt_st.purge_time = merge(st_ff.purge_time, st_ff.w_data, st_ff.w_strb);
      end else if (st_ff.aw_addr == `VBF_OFF_REMAP) begin
        wv = merge({24'h0, st_ff.remap}, st_ff.w_data, st_ff.w_strb);
        nxt_st.remap = wv[7:0];
      end else if (st_ff.aw_addr != `VBF_OFF_IRQ_STAT) begin
        nxt_st.bresp = `VBF_RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // sticky status: set wins over write-one-to-clear
    nxt_st.irq_stat = st_ff.irq_stat;
    if (wr_fire && st_ff.aw_addr == `VBF_OFF_IRQ_STAT && st_ff.w_strb[0]) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~st_ff.w_data[3:0];
    end
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

    // axi4-lite read channel
    nxt_st.arready = !st_ff.rvalid && !st_ff.arready;
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      if (s_axi_araddr == `VBF_OFF_CTRL) begin
        rd = st_ff.ctrl;
      end else if (s_axi_araddr == `VBF_OFF_STATUS) begin
        rd = {20'h0, in_map, st_ff.state, 3'h0, st_ff.error_out};
      end else if (s_axi_araddr == `VBF_OFF_IRQ_STAT) begin
        rd = {28'h0, st_ff.irq_stat};
      end else if (s_axi_araddr == `VBF_OFF_IRQ_MASK) begin
        rd = {28'h0, st_ff.irq_mask};
      end else if (s_axi_araddr == `VBF_OFF_WEIGHT) begin
        rd = {16'h0, net_weight};
      end else if (s_axi_araddr == `VBF_OFF_TARGET) begin
        rd = {16'h0, st_ff.target};
      end else if (s_axi_araddr == `VBF_OFF_TOL_LO) begin
        rd = {16'h0, st_ff.tol_lo};
      end else if (s_axi_araddr == `VBF_OFF_TOL_HI) begin
        rd = {16'h0, st_ff.tol_hi};
      end else if (s_axi_araddr == `VBF_OFF_CUT_MED) begin
        rd = {16'h0, st_ff.cut_med};
      end else if (s_axi_araddr == `VBF_OFF_CUT_FINE) begin
        rd = {16'h0, st_ff.cut_fine};
      end else if (s_axi_araddr == `VBF_OFF_PREACT) begin
        rd = {16'h0, st_ff.preact};
      end else if (s_axi_araddr == `VBF_OFF_REL_DLY) begin
        rd = st_ff.rel_dly;
      end else if (s_axi_araddr == `VBF_OFF_PUFF_TIME) begin
        rd = st_ff.puff_time;
      end else if (s_axi_araddr == `VBF_OFF_PURGE_TIME) begin
        rd = st_ff.purge_time;
      end else if (s_axi_araddr == `VBF_OFF_REMAP) begin
        rd = {24'h0, st_ff.remap};
      end else if (s_axi_araddr == `VBF_OFF_FILLED) begin
        rd = {16'h0, st_ff.filled};
      end else begin
        rd_ok = 1'b0;
      end
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd;
      nxt_st.rresp = rd_ok ? `VBF_RESP_OKAY : `VBF_RESP_SLVERR;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.state <= VBF_IDLE;
      st_ff.ctrl <= `VBF_CTRL_RESET_VAL;
      st_ff.remap <= 8'hE4;
    end else begin
      st_ff <= nxt_st;
    end
  end

  vbf_pulse_timer u_full (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(full_load),
    .count(32'(`VBF_PULSE_CYC)),
    .busy(full_busy)
  );

  vbf_pulse_timer u_done (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(done_load),
    .count(32'(`VBF_PULSE_CYC)),
    .busy(done_busy)
  );

  vbf_pulse_timer u_puff (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(puff_load),
    .count(st_ff.puff_time),
    .busy(puff_busy)
  );

  vbf_pulse_timer u_purge (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(purge_load),
    .count(st_ff.purge_time),
    .busy(purge_busy)
  );

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign out_port = st_ff.out_port;
  assign medium_feed = st_ff.medium_feed;
  assign fine_feed = st_ff.fine_feed;
  assign puff_air = st_ff.puff_air;
  assign exhaust_air = st_ff.exhaust_air;
  assign vibrate = st_ff.vibrate;
  assign purge_air = st_ff.purge_air;
  assign full_pulse = full_busy;
  assign complete_pulse = done_busy;
  assign error_out = st_ff.error_out;
  assign valve_bag_mode = st_ff.ctrl[`VBF_CTRL_ENABLE];
  assign irq = st_ff.irq;
endmodule

// *** verification/vbf_fill_seq_sva.sv ***
// assertion checker for the bag fill sequencer machine outputs
// assumes the identity port remap; bound into vbf_fill_seq from the bench
`timescale 1ns/100ps
`include "vbf_defs.svh"
module vbf_fill_seq_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // machine outputs
  input wire logic [3:0] out_port,
  input wire logic medium_feed,
  input wire logic fine_feed,
  input wire logic puff_air,
  input wire logic exhaust_air,
  input wire logic vibrate,
  input wire logic full_pulse,
  input wire logic complete_pulse,
  input wire logic error_out
);
  logic [31:0] hi_cnt_ff;
  // counts the high run of the completion pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || !complete_pulse) hi_cnt_ff <= 32'h0;
    else hi_cnt_ff <= hi_cnt_ff + 32'h1;
  end
  sequence feeding_s;
    out_port[3] || medium_feed || fine_feed;
  endsequence
  sequence released_s;
    ##[0:1] complete_pulse;
  endsequence
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  clamp_then_puff_a: assert property ($rose(puff_air) |-> out_port[1])
    else $error("puff without clamp");
  feed_clamped_a: assert property (feeding_s |-> out_port[1])
    else $error("feed without clamp");
  gate_then_feed_a: assert property ($rose(out_port[3]) |-> $past(out_port[2]))
    else $error("coarse feed before gate");
  feed_exhaust_a: assert property (feeding_s |-> exhaust_air)
    else $error("feed without exhaust");
  feed_vibrate_a: assert property (feeding_s |-> vibrate)
    else $error("feed without vibration");
  drop_after_fill_a: assert property ($fell(out_port[1]) |-> !fine_feed && !out_port[3])
    else $error("clamp opened while feeding");
  drop_complete_a: assert property ($fell(out_port[1]) |-> released_s)
    else $error("no completion on release");
  pulse_len_a: assert property ($fell(complete_pulse) |-> hi_cnt_ff == `VBF_PULSE_CYC)
    else $error("completion pulse length wrong");
  full_ok_a: assert property ($rose(full_pulse) |-> !error_out)
    else $error("full pulse with error");
endmodule

// *** verification/vbf_machine_model.sv ***
// behavioural filling machine: clamp and gate sensors follow their commands
// assumes identity port remap; weight rises by 3, 2, 1 per cycle per feed speed
`timescale 1ns/100ps
module vbf_machine_model (
  // clock
  input wire logic aclk,
  // operator switches
  input wire logic start,
  input wire logic clamp_req,
  // actuator commands
  input wire logic [3:0] out_port,
  input wire logic medium_feed,
  input wire logic fine_feed,
  // sensors
  output logic [3:0] in_port,
  output logic [15:0] net_weight
);
  logic clamp_shut = 1'b0;
  logic gate_open = 1'b0;
  initial net_weight = 16'h0;
  // sensors lag their command by a cycle, as real limit switches do
  always @(posedge aclk) begin
    clamp_shut <= out_port[1];
    gate_open <= out_port[2];
    if (!clamp_req) net_weight <= 16'h0;
    else net_weight <= net_weight + {14'h0, out_port[3], out_port[3]}
      + {14'h0, medium_feed, 1'b0} + {15'h0, fine_feed};
  end
  assign in_port = {clamp_shut, gate_open, clamp_req, start};
endmodule

// *** verification/vbf_fill_seq_bench.sv ***
// self-checking bench: axi4-lite master, machine model, three scenarios
// assumes the 200 ms pulses outlast the run, so the error fill runs first
`timescale 1ns/100ps
module vbf_fill_seq_bench;
  import vbf_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] in_port, out_port;
  logic [15:0] net_weight;
  logic medium_feed, fine_feed, puff_air, exhaust_air, vibrate, purge_air;
  logic full_pulse, complete_pulse, error_out, valve_bag_mode, irq;
  logic start = 1'b0, clamp_req = 1'b0;
  logic puffed, med, exh, err, full, comp, pur;
  int dly, miscompares = 0, n_tests = 0;
  always #25 aclk = ~aclk;
  vbf_fill_seq DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .in_port(in_port), .net_weight(net_weight),
    .out_port(out_port), .medium_feed(medium_feed), .fine_feed(fine_feed),
    .puff_air(puff_air), .exhaust_air(exhaust_air), .vibrate(vibrate), .purge_air(purge_air),
    .full_pulse(full_pulse), .complete_pulse(complete_pulse), .error_out(error_out),
    .valve_bag_mode(valve_bag_mode), .irq(irq));
  vbf_machine_model u_mach (.aclk(aclk), .start(start), .clamp_req(clamp_req),
    .out_port(out_port), .medium_feed(medium_feed), .fine_feed(fine_feed),
    .in_port(in_port), .net_weight(net_weight));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit b;
    b = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200 && !b; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        b = 1;
        r = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit b;
    b = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200 && !b; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        b = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(r, `VBF_RESP_OKAY, "write refused");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e, "read data");
    chk(r, er, "read response");
  endtask
  task automatic cfg(input logic [31:0] c, tg, cm, cf, pr, tol);
    wr(`VBF_OFF_CTRL, c);
    wr(`VBF_OFF_TARGET, tg);
    wr(`VBF_OFF_CUT_MED, cm);
    wr(`VBF_OFF_CUT_FINE, cf);
    wr(`VBF_OFF_PREACT, pr);
    wr(`VBF_OFF_TOL_LO, tol);
    wr(`VBF_OFF_TOL_HI, tol);
    wr(`VBF_OFF_REL_DLY, 32'h14);
    wr(`VBF_OFF_PUFF_TIME, 32'hA);
  endtask
  // one bag: samples at each edge until the clamp opens
  task automatic run_fill();
    bit fed, was;
    {puffed, med, exh, err, full, comp, pur, fed, was} = 9'h0;
    dly = 0;
    @(posedge aclk);
    clamp_req <= 1'b1;
    start <= 1'b1;
    for (int n = 0; n < 3000 && !comp; n++) begin
      @(posedge aclk);
      if (puff_air && !out_port[2]) puffed = 1;
      if (medium_feed) med = 1;
      if (out_port[3] && exhaust_air && vibrate) exh = 1;
      // error of the previous bag stands until this cycle starts
      if (error_out && out_port[1]) err = 1;
      if (purge_air && !fine_feed) pur = 1;
      if (full_pulse) full = 1;
      if (fed && out_port[1] && !fine_feed) dly++;
      if (fine_feed) fed = 1;
      if (was && !out_port[1]) comp = 1;
      was = out_port[1];
    end
    @(posedge aclk);
    comp = comp && complete_pulse;
    clamp_req <= 1'b0;
    start <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic t_reset();
    logic [1:0] r;
    // ready output and mode bit are up once reset is released
    chk({out_port, full_pulse, complete_pulse, error_out, irq, valve_bag_mode}, 9'h021,
      "reset outputs");
    rd_chk(`VBF_OFF_CTRL, `VBF_CTRL_RESET_VAL, `VBF_RESP_OKAY);
    rd_chk(`VBF_OFF_REMAP, 32'hE4, `VBF_RESP_OKAY);
    rd_chk(`VBF_OFF_TARGET, 32'h0, `VBF_RESP_OKAY);
    // swap start and gate functions: ready drives the gate port, so start reads back high
    start <= 1'b1;
    wr(`VBF_OFF_REMAP, 32'hC6);
    rd_chk(`VBF_OFF_STATUS, 32'h500, `VBF_RESP_OKAY);
    wr(`VBF_OFF_REMAP, 32'hE4);
    start <= 1'b0;
    rd_chk(8'h40, 32'h0, `VBF_RESP_SLVERR);
    axi_wr(8'h40, 32'hFFFF_FFFF, r);
    chk(r, `VBF_RESP_SLVERR, "unmapped write");
    $display("test reset done");
  endtask
  task automatic t_err_fill();
    cfg(32'h11, 32'h3C, 32'h28, 32'h28, 32'h5, 32'h0);
    wr(`VBF_OFF_IRQ_MASK, 32'h4);
    run_fill();
    chk(puffed, 1'b1, "no puff before gate");
    chk(med, 1'b0, "medium in two-speed");
    chk(exh, 1'b1, "no exhaust or vibration");
    chk({err, full}, 2'h2, "tolerance fail flags");
    chk(comp, 1'b1, "no completion pulse");
    chk(irq, 1'b1, "error irq");
    wr(`VBF_OFF_IRQ_STAT, 32'hF);
    @(posedge aclk);
    chk(irq, 1'b0, "irq not cleared");
    $display("test error fill done");
  endtask
  task automatic t_pass_fill();
    cfg(32'h07, 32'h64, 32'h28, 32'h50, 32'h0, 32'hA);
    wr(`VBF_OFF_PURGE_TIME, 32'h5);
    wr(`VBF_OFF_IRQ_MASK, 32'h2);
    run_fill();
    chk(puffed, 1'b1, "no puff before gate");
    chk(med, 1'b1, "no medium in three-speed");
    chk({err, full}, 2'h1, "tolerance pass flags");
    chk(error_out, 1'b0, "error not cleared");
    chk(pur, 1'b1, "no purge after fine feed");
    rd_chk(`VBF_OFF_PREACT, 32'h1, `VBF_RESP_OKAY);
    chk(dly >= 20 && dly <= 24, 1'b1, "release delay");
    chk(irq, 1'b1, "full irq");
    rd_chk(`VBF_OFF_IRQ_STAT, 32'hB, `VBF_RESP_OKAY);
    wr(`VBF_OFF_IRQ_MASK, 32'h0);
    @(posedge aclk);
    chk(irq, 1'b0, "masked irq");
    $display("test pass fill done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_err_fill();
    t_pass_fill();
    stop_test();
  end
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule
bind vbf_fill_seq vbf_fill_seq_chk u_chk (.aclk(aclk), .aresetn(aresetn), .out_port(out_port),
  .medium_feed(medium_feed), .fine_feed(fine_feed), .puff_air(puff_air),
  .exhaust_air(exhaust_air), .vibrate(vibrate), .full_pulse(full_pulse),
  .complete_pulse(complete_pulse), .error_out(error_out));
